// file: search_triplet_consts.vh
// constants for the single-wire search triplet block
`ifndef SEARCH_TRIPLET_CONSTS_VH
`define SEARCH_TRIPLET_CONSTS_VH
`define CLK_PERIOD_NS 50
`define START_LATENCY_NS 1090
`define START_LATENCY_CYC (`START_LATENCY_NS / `CLK_PERIOD_NS)
`define START_DELAY_CYC 5'd8
`define BRANCH_BIT 7
`define SLOT_STD_CYC 12'd1400
`define SLOT_OD_CYC 12'd200
`define SAMPLE_STD_CYC 12'd300
`define SAMPLE_OD_CYC 12'd40
`define READ_LOW_STD_CYC 12'd20
`define READ_LOW_OD_CYC 12'd4
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_INT_STATUS 12'h008
`define ADDR_INT_MASK 12'h00c
`define ADDR_W0L 12'h010
`define ADDR_W1L 12'h014
`define ADDR_REC 12'h018
`define PTR_STATUS 3'd1
`define RST_W0L 12'd1200
`define RST_W1L 12'd160
`define RST_REC 12'd100
`endif

// file: slot_gen.v
// one time slot generator for the single-wire bus
`timescale 1ns/1ps
`include "search_triplet_consts.vh"
module slot_gen (
   input wire clk,
   input wire reset_n,
   input wire start,
   input wire writeOne,
   input wire overdrive,
   input wire [11:0] lowZero,
   input wire [11:0] lowOne,
   input wire [11:0] recovery,
   input wire lineIn,
   output reg lineLow,
   output reg samplePulse,
   output reg sampleValue,
   output reg done
);
   reg [11:0] count;
   reg active;
   reg bitOne;
   wire [11:0] lowLen;
   wire [11:0] slotLen;
   wire [11:0] sampleAt;
   // speed picks the slot frame; write times come from live registers
   assign slotLen = overdrive ? `SLOT_OD_CYC : `SLOT_STD_CYC;
   assign sampleAt = overdrive ? `SAMPLE_OD_CYC : `SAMPLE_STD_CYC;
   assign lowLen = bitOne ? lowOne : lowZero;
   // slot counter, low phase, sample strobe and completion
   always @(posedge clk) begin
      if (!reset_n) begin
         count <= 12'h000;
         active <= 1'b0;
         bitOne <= 1'b0;
         lineLow <= 1'b0;
         samplePulse <= 1'b0;
         sampleValue <= 1'b0;
         done <= 1'b0;
      end else begin
         samplePulse <= 1'b0;
         done <= 1'b0;
         if (start && !active) begin
            active <= 1'b1;
            bitOne <= writeOne;
            count <= 12'h000;
            lineLow <= 1'b1;
         end else if (active) begin
            count <= count + 12'h001;
            if (count + 12'h001 >= lowLen)
               lineLow <= 1'b0;
            if (count == sampleAt) begin
               samplePulse <= 1'b1;
               sampleValue <= lineIn;
            end
            // recovery stretches the frame when set longer than the remainder
            if (count + 12'h001 >= slotLen && count + 12'h001 >= lowLen + recovery) begin
               active <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// file: search_triplet.v
// search triplet engine with apb registers, command port and interrupt
`timescale 1ns/1ps
`include "search_triplet_consts.vh"
module search_triplet (
   input wire clk,
   input wire reset_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire cmdValid,
   input wire [7:0] cmdParam,
   output reg cmdAck,
   output reg cmdNack,
   output reg [2:0] readPointer,
   input wire lineIn,
   output wire lineOut,
   output wire lineOe,
   output wire activePullup,
   output wire pullupSelect,
   output wire irq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_SLOT = 2'd2;
   localparam ST_NEXT = 2'd3;
   reg [1:0] state;
   reg [1:0] slotIdx;
   reg [4:0] latCount;
   reg lineBusyFlag;
   reg firstReadBit;
   reg secondReadBit;
   reg chosenDirection;
   reg branchValue;
   reg overdriveSpeedSelect;
   reg activePullupSelect;
   reg pullupResistorSelect;
   reg [11:0] writeZeroLowTime;
   reg [11:0] writeOneLowTime;
   reg [11:0] recoveryTime;
   reg [1:0] intStatus;
   reg [1:0] intMask;
   reg lineSync1;
   reg lineSync2;
   reg slotStart;
   reg slotWriteOne;
   wire slotLow;
   wire slotSample;
   wire slotSampleValue;
   wire slotDone;
   wire wrAccess;
   wire rdAccess;
   wire tripletDoneEvt;
   wire searchErrEvt;
   wire [1:0] eventBits;
   integer i;

   // apb is zero wait; unmapped addresses read zero and flag an error
   assign pready = 1'b1;
   assign wrAccess = psel && penable && pwrite;
   assign rdAccess = psel && !pwrite;
   assign pslverr = psel && penable && (paddr > `ADDR_REC || paddr[1:0] != 2'b00);

   // open drain drive: enable only while pulling low
   assign lineOut = 1'b0;
   assign lineOe = slotLow;
   assign activePullup = activePullupSelect && !slotLow;
   assign pullupSelect = pullupResistorSelect;

   // bus pin crosses into clk domain through two stages
   always @(posedge clk) begin
      if (!reset_n) begin
         lineSync1 <= 1'b1;
         lineSync2 <= 1'b1;
      end else begin
         lineSync1 <= lineIn;
         lineSync2 <= lineSync1;
      end
   end

   slot_gen u_slot (
      .clk(clk),
      .reset_n(reset_n),
      .start(slotStart),
      .writeOne(slotWriteOne),
      .overdrive(overdriveSpeedSelect),
      .lowZero(writeZeroLowTime),
      .lowOne(writeOneLowTime),
      .recovery(recoveryTime),
      .lineIn(lineSync2),
      .lineLow(slotLow),
      .samplePulse(slotSample),
      .sampleValue(slotSampleValue),
      .done(slotDone)
   );

   // triplet sequencer: three slots back to back
   always @(posedge clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         slotIdx <= 2'd0;
         latCount <= 5'd0;
         lineBusyFlag <= 1'b0;
         firstReadBit <= 1'b0;
         secondReadBit <= 1'b0;
         chosenDirection <= 1'b0;
         branchValue <= 1'b0;
         cmdAck <= 1'b0;
         cmdNack <= 1'b0;
         readPointer <= `PTR_STATUS;
         slotStart <= 1'b0;
         slotWriteOne <= 1'b0;
      end else begin
         cmdAck <= 1'b0;
         cmdNack <= 1'b0;
         slotStart <= 1'b0;
         if (cmdValid && lineBusyFlag) begin
            cmdNack <= 1'b1;
         end
         case (state)
            ST_IDLE: begin
               if (cmdValid && !lineBusyFlag) begin
                  cmdAck <= 1'b1;
                  branchValue <= cmdParam[`BRANCH_BIT];
                  readPointer <= `PTR_STATUS;
                  lineBusyFlag <= 1'b1;
                  latCount <= 5'd0;
                  slotIdx <= 2'd0;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // early start leaves room for the slot handoffs in the total budget
               latCount <= latCount + 5'd1;
               if (latCount >= `START_DELAY_CYC) begin
                  slotStart <= 1'b1;
                  slotWriteOne <= 1'b1;
                  state <= ST_SLOT;
               end
            end
            ST_SLOT: begin
               if (slotSample && slotIdx == 2'd0)
                  firstReadBit <= slotSampleValue;
               if (slotSample && slotIdx == 2'd1) begin
                  secondReadBit <= slotSampleValue;
                  // direction: reads differ -> first bit; both zero -> branch; both one -> one
                  if (firstReadBit != slotSampleValue)
                     chosenDirection <= firstReadBit;
                  else if (firstReadBit)
                     chosenDirection <= 1'b1;
                  else
                     chosenDirection <= branchValue;
               end
               if (slotDone) begin
                  if (slotIdx == 2'd2) begin
                     lineBusyFlag <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     slotIdx <= slotIdx + 2'd1;
                     state <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               // read slots write a one; third slot writes the direction
               slotStart <= 1'b1;
               slotWriteOne <= (slotIdx == 2'd2) ? chosenDirection : 1'b1;
               state <= ST_SLOT;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // interrupt events: triplet done, and both reads one
   assign tripletDoneEvt = (state == ST_SLOT) && slotDone && slotIdx == 2'd2;
   assign searchErrEvt = (state == ST_SLOT) && slotSample && slotIdx == 2'd1 &&
                         firstReadBit && slotSampleValue;
   assign eventBits = {searchErrEvt, tripletDoneEvt};
   assign irq = |(intStatus & intMask);

   // register writes; hardware set beats the write-one clear
   always @(posedge clk) begin
      if (!reset_n) begin
         overdriveSpeedSelect <= 1'b0;
         activePullupSelect <= 1'b0;
         pullupResistorSelect <= 1'b0;
         writeZeroLowTime <= `RST_W0L;
         writeOneLowTime <= `RST_W1L;
         recoveryTime <= `RST_REC;
         intStatus <= 2'b00;
         intMask <= 2'b00;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (eventBits[i])
               intStatus[i] <= 1'b1;
            else if (wrAccess && paddr == `ADDR_INT_STATUS && pwdata[i])
               intStatus[i] <= 1'b0;
         end
         if (wrAccess) begin
            case (paddr)
               `ADDR_CTRL: begin
                  overdriveSpeedSelect <= pwdata[0];
                  activePullupSelect <= pwdata[1];
                  pullupResistorSelect <= pwdata[2];
               end
               `ADDR_INT_MASK: intMask <= pwdata[1:0];
               `ADDR_W0L: writeZeroLowTime <= pwdata[11:0];
               `ADDR_W1L: writeOneLowTime <= pwdata[11:0];
               `ADDR_REC: recoveryTime <= pwdata[11:0];
               default: ;
            endcase
         end
      end
   end

   // read data registered in setup phase, valid during access
   always @(posedge clk) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (rdAccess && !penable) begin
         case (paddr)
            `ADDR_CTRL: prdata <= {29'h0, pullupResistorSelect, activePullupSelect,
                                   overdriveSpeedSelect};
            `ADDR_STATUS: prdata <= {28'h0, chosenDirection, secondReadBit,
                                     firstReadBit, lineBusyFlag};
            `ADDR_INT_STATUS: prdata <= {30'h0, intStatus};
            `ADDR_INT_MASK: prdata <= {30'h0, intMask};
            `ADDR_W0L: prdata <= {20'h0, writeZeroLowTime};
            `ADDR_W1L: prdata <= {20'h0, writeOneLowTime};
            `ADDR_REC: prdata <= {20'h0, recoveryTime};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// file: search_triplet_properties.sv
// port-level assertions for the search triplet engine
`timescale 1ns/1ps
`include "search_triplet_consts.vh"
module search_triplet_properties (
   input wire clk,
   input wire reset_n,
   input wire cmdValid,
   input wire cmdAck,
   input wire cmdNack,
   input wire [2:0] readPointer,
   input wire lineOut,
   input wire lineOe,
   input wire activePullup,
   input wire pready
);
   reg [12:0] since;
   reg [1:0] pulses;
   reg oeDly;
   // slots and cycles since the last accept; the cycle count saturates so stray pulses fail
   always @(posedge clk) begin
      oeDly <= lineOe;
      if (!reset_n || cmdAck) pulses <= 2'd0;
      else if (lineOe && !oeDly) pulses <= pulses + 2'd1;
      if (!reset_n) since <= 13'd4222;
      else if (cmdAck) since <= 13'd0;
      else if (since != 13'h1fff) since <= since + 13'd1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_ack_cause: assert property (cmdAck |-> $past(cmdValid) && !cmdNack)
      else $error("accept without a command");
   a_nack_cause: assert property (cmdNack |-> $past(cmdValid) && !cmdAck)
      else $error("refusal without a command");
   a_start_bound: assert property (cmdAck |-> ##[0:20] lineOe)
      else $error("first slot started late");
   a_pointer_status: assert property (cmdAck |=> readPointer == `PTR_STATUS)
      else $error("read pointer not on status");
   a_three_slots: assert property ($rose(lineOe) |-> pulses < 2'd3)
      else $error("more than three slots");
   a_end_bound: assert property (lineOe |-> since < 13'd4222)
      else $error("line driven after the triplet window");
   a_pullup_off: assert property (lineOe |-> !activePullup)
      else $error("active pullup while pulling low");
   a_drive_low_only: assert property (lineOut == 1'b0 && pready)
      else $error("line driven high or bus stalled");
   c_accept: cover property (cmdAck);
   c_refuse: cover property (cmdNack);
   c_write_slot: cover property ($rose(lineOe) && pulses == 2'd2);
endmodule

// file: slave_line_model.sv
// single-wire slave that answers the two read slots of a triplet
`timescale 1ns/1ps
module slave_line_model (
   input wire clk,
   input wire rearm,
   input wire [1:0] bits,
   input wire fast,
   input wire lineOe,
   output wire lineIn,
   output reg [1:0] slots,
   output reg [11:0] lastLow
);
   reg [9:0] hold = 10'd0;
   reg oeDly = 1'b0;
   // a released line floats up through the pull-up
   assign lineIn = !(lineOe || hold != 10'd0);
   // a zero answer holds low well past the sample point, not past the slot
   always @(posedge clk) begin
      oeDly <= lineOe;
      if (hold != 10'd0) hold <= hold - 10'd1;
      if (rearm) slots <= 2'd0;
      else if (lineOe && !oeDly) begin
         slots <= slots + 2'd1;
         lastLow <= 12'd1;
         if (slots < 2'd2 && !(slots == 2'd0 ? bits[1] : bits[0]))
            hold <= fast ? 10'd100 : 10'd500;
      end else if (lineOe) lastLow <= lastLow + 12'd1;
   end
endmodule

// file: test_search_triplet.sv
// self-checking bench for the search triplet engine
`timescale 1ns/1ps
`include "search_triplet_consts.vh"
module test_search_triplet;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg cmdValid = 1'b0;
   reg [7:0] cmdParam = 8'h00;
   reg rearm = 1'b0;
   reg [1:0] bits = 2'b11;
   reg fast = 1'b0;
   integer t0 = 0;
   reg [31:0] rd;
   reg err;
   wire [31:0] prdata;
   wire [2:0] readPointer;
   wire [1:0] slots;
   wire [11:0] lastLow;
   wire pready, pslverr, cmdAck, cmdNack, lineIn, lineOut, lineOe, activePullup, pullupSelect, irq;
   integer mismatches = 0;
   integer compares = 0;
   integer cycles = 0;
   search_triplet u_search_triplet (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmdValid(cmdValid), .cmdParam(cmdParam),
      .cmdAck(cmdAck), .cmdNack(cmdNack), .readPointer(readPointer), .lineIn(lineIn),
      .lineOut(lineOut), .lineOe(lineOe), .activePullup(activePullup),
      .pullupSelect(pullupSelect), .irq(irq));
   slave_line_model u_slave_line_model (.clk(clk), .rearm(rearm), .bits(bits), .fast(fast),
      .lineOe(lineOe), .lineIn(lineIn), .slots(slots), .lastLow(lastLow));
   always #25 clk = ~clk;
   // a hang ends the run as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches = mismatches + 1;
         complete_run;
      end
   end
   task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   // one apb transfer; waits a clock first so signals never change twice at one edge
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (pready !== 1'b1) @(posedge clk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task pulse(input [7:0] prm);
      begin
         @(posedge clk);
         cmdValid <= 1'b1;
         cmdParam <= prm;
         @(posedge clk);
         cmdValid <= 1'b0;
         @(negedge clk);
      end
   endtask
   // one triplet against the slave with a refusal while busy, then results and interrupt
   task trip(input [1:0] b, input [7:0] prm, input [11:0] low, input [3:0] st, input [1:0] ev);
      begin
         bits <= b;
         rearm <= 1'b1;
         pulse(prm);
         rearm <= 1'b0;
         t0 = cycles;
         check("accept", cmdAck, 1);
         check("pointer", readPointer, `PTR_STATUS);
         pulse(8'h80);
         check("refuse", {cmdNack, cmdAck}, 2'b10);
         apb(1'b0, `ADDR_STATUS, 0);
         check("busy", rd[0], 1);
         while (rd[0] !== 1'b0) apb(1'b0, `ADDR_STATUS, 0);
         // a few cycles of slack cover the polling granularity
         check("duration", cycles - t0 <= 3 * (fast ? `SLOT_OD_CYC : `SLOT_STD_CYC) +
            `START_LATENCY_CYC + 4, 1);
         check("status", rd, st);
         check("slots", slots, 3);
         check("write low", lastLow, low);
         apb(1'b0, `ADDR_INT_STATUS, 0);
         check("events", rd, ev);
         check("irq on", irq, 1);
         apb(1'b1, `ADDR_INT_MASK, 0);
         @(negedge clk);
         check("irq masked", irq, 0);
         apb(1'b1, `ADDR_INT_MASK, 3);
         apb(1'b1, `ADDR_INT_STATUS, 3);
         @(negedge clk);
         check("irq off", irq, 0);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, `ADDR_W0L, 0);
      check("w0 reset", rd, `RST_W0L);
      apb(1'b0, 12'h100, 0);
      check("unmapped", rd, 0);
      check("slverr", err, 1);
      apb(1'b1, `ADDR_W0L, 900);
      apb(1'b1, `ADDR_INT_MASK, 3);
      trip(2'b00, 8'h7f, 12'd900, 4'b0000, 2'b01);
      trip(2'b00, 8'h80, `RST_W1L, 4'b1000, 2'b01);
      trip(2'b01, 8'h80, 12'd900, 4'b0100, 2'b01);
      trip(2'b10, 8'h00, `RST_W1L, 4'b1010, 2'b01);
      trip(2'b11, 8'h00, `RST_W1L, 4'b1110, 2'b11);
      // overdrive frame with short write times and both pull-up controls on
      fast <= 1'b1;
      apb(1'b1, `ADDR_CTRL, 7);
      apb(1'b1, `ADDR_W1L, 8);
      apb(1'b1, `ADDR_W0L, 60);
      @(negedge clk);
      check("pullup sel", pullupSelect, 1);
      check("active pu", activePullup, 1);
      trip(2'b01, 8'h80, 12'd60, 4'b0100, 2'b01);
      trip(2'b00, 8'h80, 12'd8, 4'b1000, 2'b01);
      complete_run;
   end
   task complete_run;
      begin
         if (mismatches == 0 && compares > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
endmodule
bind search_triplet search_triplet_properties u_search_triplet_properties (.clk(clk),
   .reset_n(reset_n), .cmdValid(cmdValid), .cmdAck(cmdAck), .cmdNack(cmdNack),
   .readPointer(readPointer), .lineOut(lineOut), .lineOe(lineOe),
   .activePullup(activePullup), .pready(pready));
